// ===== design/msd_defines.svh
`ifndef MSD_DEFINES_SVH
`define MSD_DEFINES_SVH

// ****************************************************************
// widths and sizes
// ****************************************************************
`define MSD_BUS_W          66
`define MSD_NUM_TERMS      40
`define MSD_TERMS_PER_SEL  3
`define MSD_BOOT_TERM_BASE 24
`define MSD_SRAM_TERM_BASE 36
`define MSD_REGS_TERM      39

// ****************************************************************
// register offsets inside the control register space
// ****************************************************************
`define MSD_OFS_PAGE       8'hE0
`define MSD_OFS_SPACE_MAP  8'hE2
`define MSD_OFS_ID0        8'hF0
`define MSD_OFS_ID1        8'hF2

// ****************************************************************
// space map fields and reset values
// ****************************************************************
`define MSD_SM_PIO         7
`define MSD_SM_MAIN_FLASH_DATA_ACCESS     4
`define MSD_SM_BOOT_DATA   3
`define MSD_SM_MAIN_FLASH_CODE_ACCESS     2
`define MSD_SM_BOOT_CODE   1
`define MSD_SM_SRAM_CODE   0
`define MSD_SM_USED_MASK   8'h9F
`define MSD_SM_RESET       8'h00
`define MSD_PAGE_RESET     8'h00

// ****************************************************************
// memory identification contents
// ****************************************************************
`define MSD_ID0_VALUE      8'h15
`define MSD_ID1_VALUE      8'h01
`define MSD_ID1_USED_MASK  8'h3F

// ****************************************************************
// power management fields and timing
// ****************************************************************
`define MSD_PM0_TURBO_BIT  3
`define MSD_CLK_NS         25
`define MSD_STBY_NS        70
`define MSD_STBY_CYC       ((`MSD_STBY_NS + `MSD_CLK_NS - 1) / `MSD_CLK_NS)

`endif

// ===== design/msd_pkg.sv
`include "msd_defines.svh"

package msd_pkg;

    // one product term: literals taken true and complemented
    typedef struct packed {
        logic [`MSD_BUS_W-1:0] use_true;
        logic [`MSD_BUS_W-1:0] use_comp;
    } msd_term_t;

    typedef struct packed {
        logic [7:0] main;
        logic [3:0] boot;
        logic       sram;
        logic       regs;
    } msd_selects_t;

    typedef struct packed {
        logic [7:0] pa;
        logic [7:0] pb;
        logic [7:0] pc;
        logic [3:0] pd;
        logic [7:0] pf;
    } msd_port_inputs_t;

    typedef enum logic [1:0] {
        MSD_ACTIVE  = 2'b01,
        MSD_STANDBY = 2'b10
    } msd_array_state_t;

endpackage

// ===== design/msd_input_bus.sv
`include "msd_defines.svh"

module msd_input_bus (
    input  wire logic [19:0]                host_addr_i,
    input  wire logic                       sep_space_i,
    input  wire logic [2:0]                 host_control_inputs_i,
    input  wire logic [4:0]                 power_mgmt_reg2_i,
    input  wire logic                       reset_active_i,
    input  wire logic                       power_down_signal_i,
    input  wire msd_pkg::msd_port_inputs_t  port_in_i,
    input  wire logic [7:0]                 page_bits_i,
    input  wire logic                       ready_busy_i,
    output logic [`MSD_BUS_W-1:0]           array_bus_o
);

    logic [15:0] addr_sel;
    logic [2:0]  ctl_gated;

    // ****************************************************************
    // address choice and control blocking
    // ****************************************************************
    // upper address window when sep_space_i is set, low 16 address bits otherwise
    assign addr_sel = sep_space_i ? host_addr_i[19:4] : host_addr_i[15:0];

    assign ctl_gated = host_control_inputs_i & ~power_mgmt_reg2_i[2:0];

    // ****************************************************************
    // 66 signal input bus
    // ****************************************************************
    // bus composition order
    assign array_bus_o = {ready_busy_i, page_bits_i, port_in_i.pf,
                          port_in_i.pd, port_in_i.pc, port_in_i.pb,
                          port_in_i.pa, power_down_signal_i,
                          reset_active_i, ctl_gated, addr_sel};

endmodule

// ===== design/msd_priority.sv
module msd_priority (
    input  wire msd_pkg::msd_selects_t raw_i,
    output msd_pkg::msd_selects_t      win_o
);

    logic level1;
    logic level2;

    // ****************************************************************
    // three level overlap resolution
    // ****************************************************************
    // level one beats all
    assign level1 = raw_i.sram | raw_i.regs;
    assign level2 = |raw_i.boot;

    assign win_o.sram = raw_i.sram;
    assign win_o.regs = raw_i.regs;
    assign win_o.boot = level1 ? 4'h0 : raw_i.boot;
    assign win_o.main = (level1 | level2) ? 8'h00 : raw_i.main;

endmodule

// ===== design/msd_top.sv
`include "msd_defines.svh"

module msd_top (
    input  wire logic                       core_clk_i,
    input  wire logic                       reset_n_i,
    input  wire logic [19:0]                host_addr_i,
    input  wire logic [15:0]                host_data_i,
    input  wire logic                       host_rd_i,
    input  wire logic                       host_wr_i,
    input  wire logic                       code_fetch_strobe_i,
    input  wire logic                       sep_space_i,
    input  wire logic [2:0]                 host_control_inputs_i,
    input  wire logic                       power_down_signal_i,
    input  wire logic                       ready_busy_i,
    input  wire msd_pkg::msd_port_inputs_t  port_in_i,
    input  wire logic [7:0]                 power_mgmt_reg0_i,
    input  wire logic [4:0]                 power_mgmt_reg2_i,
    input  wire logic [7:0]                 space_map_init_i,
    input  wire msd_pkg::msd_term_t         select_terms_i [`MSD_NUM_TERMS],
    output logic [7:0]                      main_sector_select_o,
    output logic [3:0]                      boot_sector_select_o,
    output logic                            sram_select_o,
    output logic                            regs_select_o,
    output logic [7:0]                      main_flash_enable_o,
    output logic [3:0]                      boot_flash_enable_o,
    output logic                            sram_enable_o,
    output logic [15:0]                     host_data_o,
    output logic                            host_data_oe_o,
    output logic [7:0]                      page_bits_o,
    output logic                            port_io_enable_o,
    output logic [`MSD_BUS_W-1:0]           array_bus_o,
    output logic                            array_standby_o
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic                       rst_meta_n;
    logic                       rst_sync_n;
    logic                       init_done;
    logic [7:0]                 page_reg;
    logic [7:0]                 space_map;
    logic [`MSD_BUS_W-1:0]      bus_now;
    logic [`MSD_BUS_W-1:0]      bus_prev;
    logic                       bus_changed;
    logic [1:0]                 stable_cnt;
    msd_pkg::msd_array_state_t  arr_state;
    msd_pkg::msd_array_state_t  next_arr_state;
    msd_pkg::msd_selects_t      eval_sel;
    msd_pkg::msd_selects_t      held_sel;
    msd_pkg::msd_selects_t      raw_sel;
    msd_pkg::msd_selects_t      win_sel;
    logic                       turbo_off;
    logic                       main_access;
    logic                       boot_access;
    logic                       sram_access;
    logic                       reg_access;
    logic [7:0]                 reg_ofs;
    logic                       reg_known;
    logic [7:0]                 reg_rdata;
    logic [7:0]                 id0_value;
    logic [7:0]                 id1_value;

    // ****************************************************************
    // functions
    // ****************************************************************
    // a term with no literal is unused and never fires
    function automatic logic term_hit(
        input msd_pkg::msd_term_t    t,
        input logic [`MSD_BUS_W-1:0] b
    );
        logic any_lit;
        any_lit  = |(t.use_true | t.use_comp);
        term_hit = any_lit
                   && ((b & t.use_true) == t.use_true)
                   && ((~b & t.use_comp) == t.use_comp);
    endfunction

    function automatic logic sel_hit(
        input msd_pkg::msd_term_t    t0,
        input msd_pkg::msd_term_t    t1,
        input msd_pkg::msd_term_t    t2,
        input logic [`MSD_BUS_W-1:0] b
    );
        sel_hit = term_hit(t0, b) | term_hit(t1, b) | term_hit(t2, b);
    endfunction

    // ****************************************************************
    // reset release
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ****************************************************************
    // logic array input bus
    // ****************************************************************
    msd_input_bus u_input_bus (
        .host_addr_i           (host_addr_i),
        .sep_space_i           (sep_space_i),
        .host_control_inputs_i (host_control_inputs_i),
        .power_mgmt_reg2_i     (power_mgmt_reg2_i),
        .reset_active_i        (~rst_sync_n),
        .power_down_signal_i   (power_down_signal_i),
        .port_in_i             (port_in_i),
        .page_bits_i           (page_reg),
        .ready_busy_i          (ready_busy_i),
        .array_bus_o           (bus_now)
    );

    // page bits exported for general use
    assign page_bits_o = page_reg;
    assign array_bus_o = bus_now;

    // ****************************************************************
    // decode array equations
    // ****************************************************************
    // true and complement literals
    always_comb
    begin
        eval_sel = '0;
        for (int i = 0; i < 8; i++)
        begin
            eval_sel.main[i] = sel_hit(
                select_terms_i[`MSD_TERMS_PER_SEL*i],
                select_terms_i[`MSD_TERMS_PER_SEL*i+1],
                select_terms_i[`MSD_TERMS_PER_SEL*i+2], bus_now);
        end
        for (int j = 0; j < 4; j++)
        begin
            eval_sel.boot[j] = sel_hit(
                select_terms_i[`MSD_BOOT_TERM_BASE+`MSD_TERMS_PER_SEL*j],
                select_terms_i[`MSD_BOOT_TERM_BASE+`MSD_TERMS_PER_SEL*j+1],
                select_terms_i[`MSD_BOOT_TERM_BASE+`MSD_TERMS_PER_SEL*j+2],
                bus_now);
        end
        eval_sel.sram = sel_hit(select_terms_i[`MSD_SRAM_TERM_BASE],
                                select_terms_i[`MSD_SRAM_TERM_BASE+1],
                                select_terms_i[`MSD_SRAM_TERM_BASE+2],
                                bus_now);
        eval_sel.regs = term_hit(select_terms_i[`MSD_REGS_TERM], bus_now);
    end

    // ****************************************************************
    // turbo standby
    // ****************************************************************
    assign turbo_off   = ~power_mgmt_reg0_i[`MSD_PM0_TURBO_BIT];
    assign bus_changed = (bus_now != bus_prev);

    always_ff @(posedge core_clk_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            bus_prev <= '0;
        end
        else
        begin
            bus_prev <= bus_now;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            stable_cnt <= 2'h0;
        end
        else if (bus_changed || !turbo_off)
        begin
            stable_cnt <= 2'h0;
        end
        else if (stable_cnt != 2'(`MSD_STBY_CYC))
        begin
            stable_cnt <= stable_cnt + 2'h1;
        end
    end

    always_comb
    begin
        next_arr_state = arr_state;
        case (arr_state)
            msd_pkg::MSD_ACTIVE:
            begin
                if (turbo_off && !bus_changed
                    && stable_cnt == 2'(`MSD_STBY_CYC - 1))
                begin
                    next_arr_state = msd_pkg::MSD_STANDBY;
                end
            end
            msd_pkg::MSD_STANDBY:
            begin
                if (bus_changed || !turbo_off)
                begin
                    next_arr_state = msd_pkg::MSD_ACTIVE;
                end
            end
            default:
            begin
                next_arr_state = msd_pkg::MSD_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            arr_state <= msd_pkg::MSD_ACTIVE;
        end
        else
        begin
            arr_state <= next_arr_state;
        end
    end

    // held outputs while in standby, refreshed when active
    always_ff @(posedge core_clk_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            held_sel <= '0;
        end
        else if (arr_state == msd_pkg::MSD_ACTIVE)
        begin
            held_sel <= eval_sel;
        end
    end

    assign raw_sel = (arr_state == msd_pkg::MSD_STANDBY) ? held_sel
                                                          : eval_sel;
    assign array_standby_o = (arr_state == msd_pkg::MSD_STANDBY);

    assign main_sector_select_o = raw_sel.main;
    assign boot_sector_select_o = raw_sel.boot;
    assign sram_select_o        = raw_sel.sram;

    // ****************************************************************
    // priority and space gating
    // ****************************************************************
    msd_priority u_priority (
        .raw_i (raw_sel),
        .win_o (win_sel)
    );

    assign regs_select_o = win_sel.regs;

    // code, data or both per memory
    always_comb
    begin
        if (sep_space_i)
        begin
            // strobe reach per space map bit
            main_access = host_wr_i
                | (host_rd_i & space_map[`MSD_SM_MAIN_FLASH_DATA_ACCESS])
                | (code_fetch_strobe_i & space_map[`MSD_SM_MAIN_FLASH_CODE_ACCESS]);
            boot_access = host_wr_i
                | (host_rd_i & space_map[`MSD_SM_BOOT_DATA])
                | (code_fetch_strobe_i & space_map[`MSD_SM_BOOT_CODE]);
            sram_access = host_wr_i | host_rd_i
                | (code_fetch_strobe_i & space_map[`MSD_SM_SRAM_CODE]);
        end
        else
        begin
            main_access = host_wr_i | host_rd_i;
            boot_access = host_wr_i | host_rd_i;
            sram_access = host_wr_i | host_rd_i;
        end
    end

    // sram enabled by its select and a read, write or, with sep_space_i set, space-map-gated fetch strobe
    assign main_flash_enable_o = win_sel.main & {8{main_access}};
    assign boot_flash_enable_o = win_sel.boot & {4{boot_access}};
    assign sram_enable_o       = win_sel.sram & sram_access;

    // ****************************************************************
    // control register space
    // ****************************************************************
    assign reg_ofs    = host_addr_i[7:0];
    assign reg_access = win_sel.regs;

    assign id0_value = `MSD_ID0_VALUE;
    assign id1_value = `MSD_ID1_VALUE & `MSD_ID1_USED_MASK;

    always_comb
    begin
        reg_known = 1'b1;
        case (reg_ofs)
            `MSD_OFS_PAGE:      reg_rdata = page_reg;
            `MSD_OFS_SPACE_MAP: reg_rdata = space_map;
            `MSD_OFS_ID0:       reg_rdata = id0_value;
            `MSD_OFS_ID1:       reg_rdata = id1_value;
            default:
            begin
                reg_rdata = 8'h00;
                reg_known = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            page_reg <= `MSD_PAGE_RESET;
        end
        else if (host_wr_i && reg_access && reg_ofs == `MSD_OFS_PAGE)
        begin
            page_reg <= host_data_i[7:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            init_done <= 1'b0;
            space_map <= `MSD_SM_RESET;
        end
        else if (!init_done)
        begin
            init_done <= 1'b1;
            space_map <= space_map_init_i & `MSD_SM_USED_MASK;
        end
        else if (host_wr_i && reg_access
                 && reg_ofs == `MSD_OFS_SPACE_MAP)
        begin
            space_map <= host_data_i[7:0] & `MSD_SM_USED_MASK;
        end
    end

    assign port_io_enable_o = space_map[`MSD_SM_PIO];

    // drive data only for register reads
    always_ff @(posedge core_clk_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            host_data_o    <= 16'h0000;
            host_data_oe_o <= 1'b0;
        end
        else if (host_rd_i && reg_access)
        begin
            host_data_o    <= {8'h00, reg_rdata};
            host_data_oe_o <= 1'b1;
        end
        else
        begin
            host_data_o    <= 16'h0000;
            host_data_oe_o <= 1'b0;
        end
    end

    // unmapped offsets inside the register space read as zero
    logic unused_known;
    assign unused_known = reg_known;

endmodule

// ===== test/msd_chk.sv
module msd_chk (
    input wire logic        core_clk_i,
    input wire logic        reset_n_i,
    input wire logic [19:0] host_addr_i,
    input wire logic [15:0] host_data_i,
    input wire logic        host_rd_i,
    input wire logic        host_wr_i,
    input wire logic        sep_space_i,
    input wire logic [7:0]  power_mgmt_reg0_i,
    input wire logic [4:0]  power_mgmt_reg2_i,
    input wire logic [3:0]  boot_sector_select_o,
    input wire logic        sram_select_o,
    input wire logic        regs_select_o,
    input wire logic [7:0]  main_flash_enable_o,
    input wire logic [3:0]  boot_flash_enable_o,
    input wire logic        sram_enable_o,
    input wire logic [15:0] host_data_o,
    input wire logic        host_data_oe_o,
    input wire logic [7:0]  page_bits_o,
    input wire logic [65:0] array_bus_o,
    input wire logic        array_standby_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // helpers and assertions
    // ****************************************************************
    logic [2:0] live;
    logic [7:0] wdat;
    logic       turbo_q;
    logic       hot;
    logic       pg_wr;

    // internal reset copy live[2] is three flops late
    assign hot   = turbo_q & power_mgmt_reg0_i[3];
    assign pg_wr = live[2] & host_wr_i & regs_select_o
                 & (host_addr_i[7:0] == 8'hE0);

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            live <= 3'b000;
        else
            live <= {live[1:0], 1'b1};
    end

    always_ff @(posedge core_clk_i)
    begin
        wdat    <= host_data_i[7:0];
        turbo_q <= power_mgmt_reg0_i[3];
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_boot_over_main:
    assert property (|boot_sector_select_o |-> main_flash_enable_o == 8'h00)
        else $error("main flash enabled under boot select");
    a_sram_over_flash:
    assert property ((sram_select_o || regs_select_o) |->
        (main_flash_enable_o == 8'h00) && (boot_flash_enable_o == 4'h0))
        else $error("flash enabled under sram or register select");
    a_sram_by_select:
    assert property (sram_enable_o |-> sram_select_o)
        else $error("sram enabled without its select");
    a_read_answer:
    assert property (live[2] && host_rd_i && regs_select_o |=>
        host_data_oe_o && (host_data_o[15:8] == 8'h00))
        else $error("register read not answered");
    a_no_sel_quiet:
    assert property (host_rd_i && !regs_select_o |=> !host_data_oe_o)
        else $error("data driven without select");
    a_page_write:
    assert property (pg_wr |=> page_bits_o == wdat)
        else $error("page register not written");
    a_page_hold:
    assert property (!pg_wr |=> $stable(page_bits_o))
        else $error("page register changed without write");
    a_page_on_bus:
    assert property (hot |-> array_bus_o[64:57] == page_bits_o)
        else $error("page bits missing from array bus");
    a_ctl_blocked:
    assert property (hot |->
        (array_bus_o[18:16] & power_mgmt_reg2_i[2:0]) == 3'b000)
        else $error("blocked control input reached array");
    a_split_addr:
    assert property (hot |-> array_bus_o[15:0] ==
        (sep_space_i ? host_addr_i[19:4] : host_addr_i[15:0]))
        else $error("array address lines wrong");
    a_turbo_awake:
    assert property (hot |-> !array_standby_o)
        else $error("standby with turbo on");
    a_wake_bound:
    assert property (array_standby_o && !$stable(host_addr_i) |=>
        !array_standby_o)
        else $error("array stayed in standby after change");
endmodule

bind msd_top msd_chk chk_u (.*);

// ===== test/msd_host_model.sv
module msd_host_model (
    input  wire logic        core_clk_i,
    input  wire logic [15:0] host_data_o,
    input  wire logic        host_data_oe_o,
    output logic      [19:0] host_addr_i,
    output logic      [15:0] host_data_i,
    output logic             host_rd_i,
    output logic             host_wr_i,
    output logic             code_fetch_strobe_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // host bus cycles
    // ****************************************************************
    initial
    begin
        host_addr_i = 20'h00000;
        host_data_i = 16'h5A5A;
        host_rd_i = 1'b0;
        host_wr_i = 1'b0;
        code_fetch_strobe_i = 1'b0;
    end

    task automatic acc(input logic w, input logic [19:0] a,
                       input logic [7:0] d, output logic [16:0] q);
        @(negedge core_clk_i);
        host_addr_i = a;
        host_data_i = {8'h00, d};
        host_wr_i = w;
        host_rd_i = !w;
        code_fetch_strobe_i = 1'b0;
        @(negedge core_clk_i);
        q = {host_data_oe_o, host_data_o};
        host_wr_i = 1'b0;
        host_rd_i = 1'b0;
        // released data must not look valid
        host_data_i = ~host_data_i;
    endtask

    task automatic hold(input logic [19:0] a, input logic r,
                        input logic f);
        @(negedge core_clk_i);
        host_addr_i = a;
        host_rd_i = r;
        code_fetch_strobe_i = f;
        host_wr_i = 1'b0;
    endtask
endmodule

// ===== test/tb_top.sv
`include "msd_defines.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk_i;
    logic        reset_n_i;
    logic        sep_space_i;
    logic [2:0]  host_control_inputs_i;
    logic        power_down_signal_i;
    logic        ready_busy_i;
    logic [7:0]  power_mgmt_reg0_i;
    logic [4:0]  power_mgmt_reg2_i;
    logic [7:0]  space_map_init_i;
    logic [19:0] host_addr_i;
    logic [15:0] host_data_i;
    logic        host_rd_i;
    logic        host_wr_i;
    logic        code_fetch_strobe_i;
    logic [7:0]  main_sector_select_o;
    logic [3:0]  boot_sector_select_o;
    logic        sram_select_o;
    logic        regs_select_o;
    logic [7:0]  main_flash_enable_o;
    logic [3:0]  boot_flash_enable_o;
    logic        sram_enable_o;
    logic [15:0] host_data_o;
    logic        host_data_oe_o;
    logic [7:0]  page_bits_o;
    logic        port_io_enable_o;
    logic [65:0] array_bus_o;
    logic        array_standby_o;
    int          err_total;
    int          comparisons;
    int          k;
    int          s;
    int          m;
    logic [16:0] q;
    logic [7:0]  sm;
    logic        e;
    logic [19:0] mix [4] = '{20'h04000, 20'h06000, 20'h07000, 20'h0F000};
    logic [7:0]  maps [3] = '{8'h0C, 8'h14, 8'h13};
    msd_pkg::msd_port_inputs_t port_in_i;
    msd_pkg::msd_term_t        select_terms_i [`MSD_NUM_TERMS];

    msd_top dut_u (.*);
    msd_host_model host_u (.*);

    initial
    begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input logic [65:0] got, input logic [65:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic rg(input logic w, input logic [7:0] o,
                      input logic [7:0] d);
        host_u.acc(w, {12'h880, o}, d, q);
    endtask

    task automatic probe(input logic [19:0] a, input logic r,
                         input logic f);
        host_u.hold(a, r, f);
        @(posedge core_clk_i);
        #1;
    endtask

    initial
    begin
        err_total = 0;
        comparisons = 0;
        reset_n_i = 1'b0;
        sep_space_i = 1'b0;
        host_control_inputs_i = 3'b111;
        power_down_signal_i = 1'b1;
        ready_busy_i = 1'b1;
        port_in_i = {8'hA1, 8'hB2, 8'hC3, 4'h4, 8'hD5};
        power_mgmt_reg0_i = 8'h08;
        power_mgmt_reg2_i = 5'h00;
        space_map_init_i = 8'hFF;
        foreach (select_terms_i[i])
            select_terms_i[i] = '0;
        select_terms_i[0].use_true[14] = 1'b1;
        select_terms_i[3].use_true[57] = 1'b1;
        select_terms_i[3].use_comp[14] = 1'b1;
        select_terms_i[24].use_true[13] = 1'b1;
        select_terms_i[36].use_true[12] = 1'b1;
        select_terms_i[36].use_comp[15] = 1'b1;
        select_terms_i[39].use_true[15] = 1'b1;
        repeat (3) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        rg(0, 8'hE2, 8'h00);
        chk(q, 17'h1009F);
        chk(port_io_enable_o, 1'b1);
        rg(1, 8'hF0, 8'hAA);
        rg(0, 8'hF0, 8'h00);
        chk(q, {9'h100, `MSD_ID0_VALUE});
        rg(1, 8'hF2, 8'hFF);
        rg(0, 8'hF2, 8'h00);
        chk(q, {9'h100, `MSD_ID1_VALUE});
        rg(0, 8'h10, 8'h00);
        chk(q, 17'h10000);
        rg(1, 8'hE0, 8'h01);
        rg(0, 8'hE0, 8'h00);
        chk(q, 17'h10001);
        probe(20'h00000, 0, 0);
        chk(main_sector_select_o[1], 1'b1);
        @(negedge core_clk_i);
        power_mgmt_reg2_i = 5'h05;
        #1;
        chk(array_bus_o[65:16], {9'h101, 8'hD5, 4'h4, 8'hC3, 8'hB2,
            8'hA1, 2'b10, 3'b010});
        host_u.acc(1, 20'h000E0, 8'h77, q);
        host_u.acc(0, 20'h000E0, 8'h00, q);
        chk({q[16], page_bits_o}, 9'h001);
        for (k = 0; k < 4; k++)
        begin
            probe(mix[k], 1, 0);
            chk({main_flash_enable_o[0], boot_flash_enable_o[0],
                sram_enable_o}, 3'b100 >> k);
            if (k == 2)
                chk({main_sector_select_o[0], boot_sector_select_o[0],
                    sram_select_o}, 3'b111);
        end
        @(negedge core_clk_i);
        sep_space_i = 1'b1;
        for (m = 0; m < 3; m++)
        begin
            sm = maps[m];
            rg(1, 8'hE2, sm);
            chk(port_io_enable_o, 1'b0);
            for (k = 0; k < 3; k++)
                for (s = 0; s < 2; s++)
                begin
                    probe({mix[k][15:12], mix[k][15:0]}, s == 0, s == 1);
                    e = (k == 0) ? (s ? sm[2] : sm[4]) :
                        (k == 1) ? (s ? sm[1] : sm[3]) : (s ? sm[0] : 1'b1);
                    chk({main_flash_enable_o[0], boot_flash_enable_o[0],
                        sram_enable_o}, {k == 0, k == 1, k == 2} & {3{e}});
                    chk(array_bus_o[15:0], mix[k][15:0] >> 4 |
                        {mix[k][15:12], 12'h000});
                end
        end
        probe(20'h00000, 0, 0);
        @(negedge core_clk_i);
        sep_space_i = 1'b0;
        power_mgmt_reg0_i = 8'h00;
        for (k = 0; k < 8 && array_standby_o !== 1'b1; k++)
        begin
            @(posedge core_clk_i);
            #1;
        end
        chk(array_standby_o, 1'b1);
        if (array_standby_o === 1'b1)
        begin
            probe(20'h04000, 0, 0);
            @(posedge core_clk_i);
            #1;
            chk(main_sector_select_o[0], 1'b1);
        end
        wrap_up();
    end
endmodule
